// ---- logic/asrc_seq_ctrl.sv ----
// sequence, result placement and freeze control of the converter
// assumes a converter core that starts on conv_start_o and reports conv_done_i
// Function
// - any control register write aborts the running sequence; only a start register write starts a new one
// - length field resets to four conversions
// - length field decode, top bit or zero low bits mean eight
// - fixed placement puts the nth result in the nth register
// - wrapping placement keeps the counter across the sequences of a continuous scan
// - in wrapping placement the pointer wraps from last to first register
// - current conversion counter is readable in the status register
// - abort or any converter control write clears the counter
// - one completion flag per result register, set on new result
// - breakpoint field selects continue, reserved, finish-then-stop, stop at once
// - finish-then-stop lets the running conversion store before halting
//
// Decided for this implementation: the Wishbone slave port.
`include "asrc_map.svh"
module asrc_seq_ctrl
    import asrc_pkg::*;
(
    input  wire logic        clk_i,        // 250 MHz bus clock
    input  wire logic        rst_i,        // synchronous reset, active high
    input  wire logic        cyc_i,        // wishbone cycle
    input  wire logic        stb_i,        // wishbone strobe
    input  wire logic        we_i,         // wishbone write
    input  wire logic [5:0]  adr_i,        // wishbone byte address
    input  wire logic [3:0]  sel_i,        // wishbone byte enables
    input  wire logic [31:0] dat_i,        // wishbone write data
    output logic      [31:0] dat_o,        // wishbone read data
    output logic             ack_o,        // wishbone acknowledge
    input  wire logic        freeze_i,     // debug breakpoint level
    input  wire logic        conv_done_i,  // core finished one conversion, pulse
    input  wire logic        ccf_clr_i,    // unit clears flags, one bit per result
    input  wire logic [7:0]  ccf_clr_mask_i, // which flags to clear
    output logic             conv_start_o, // start a conversion, pulse
    output logic             conv_abort_o, // abort core conversion, pulse
    output logic      [2:0]  result_idx_o, // result register to receive result
    output logic      [7:0]  ccf_o,        // completion flags
    output logic             irq_o         // level interrupt
);
    // ****************************************************************
    // decode and state
    // ****************************************************************
    asrc_regs_t   r_ff;
    asrc_regs_t   nxt_r;
    logic [3:0]   seq_len;
    logic [3:0]   idx;
    logic         wr;
    logic         rd;
    logic         lane0;
    logic         conv_ctrl_wr;
    logic [1:0]   brk;
    logic         wrap_mode;

    asrc_len_decode u_len (
        .len_field_i (r_ff.ctrl[`ASRC_LEN_MSB:`ASRC_LEN_LSB]),
        .len_o       (seq_len)
    );

    // bus qualifiers; ack drops the cycle after it is given
    assign idx          = adr_i[5:2];
    assign wr           = cyc_i && stb_i && we_i && !r_ff.ack;
    assign rd           = cyc_i && stb_i && !we_i && !r_ff.ack;
    assign lane0        = sel_i[0];
    // control registers occupy indices 0 to 5; only a byte-0 write counts
    assign conv_ctrl_wr = wr && lane0 && (idx <= `ASRC_IDX_START);
    assign brk          = r_ff.ctrl[`ASRC_BRK_MSB:`ASRC_BRK_LSB];
    assign wrap_mode    = r_ff.ctrl[`ASRC_WRAP_BIT];

    // ****************************************************************
    // next-state logic
    // ****************************************************************
    always_comb begin
        logic       ev_seq;
        logic       ev_conv;
        logic       ev_abort;
        logic [2:0] clr;
        logic       last;
        ev_seq   = 1'b0;
        ev_conv  = 1'b0;
        ev_abort = 1'b0;
        clr      = 3'h0;
        last     = 1'b0;
        nxt_r    = r_ff;
        nxt_r.ack        = 1'b0;
        nxt_r.conv_start = 1'b0;
        nxt_r.conv_abort = 1'b0;

        // converter sequencing
        case (r_ff.state)
            ASRC_IDLE: begin
                if (r_ff.start_pend && !(freeze_i && brk[1])) begin
                    nxt_r.start_pend = 1'b0;
                    nxt_r.conv_start = 1'b1;
                    nxt_r.state      = ASRC_CONV;
                end
            end
            ASRC_CONV: begin
                if (conv_done_i) begin
                    ev_conv = 1'b1;
                    // store result, raise its flag, advance counter
                    nxt_r.ccf[r_ff.cnt] = 1'b1;
                    nxt_r.cnt = r_ff.cnt + 3'h1;
                    last = (r_ff.done_in_seq + 4'h1 >= seq_len);
                    nxt_r.done_in_seq = r_ff.done_in_seq + 4'h1;
                    if (last) begin
                        ev_seq = 1'b1;
                        nxt_r.done_in_seq = 4'h0;
                        if (!wrap_mode) begin
                            nxt_r.cnt = 3'h0;
                        end                                  // else keep counting
                    end
                    if (last && !r_ff.scan) begin
                        nxt_r.state = ASRC_IDLE;
                    end else if (freeze_i && brk == 2'b10) begin
                        nxt_r.state = ASRC_FROZEN;
                    end else if (freeze_i && brk == 2'b11) begin
                        nxt_r.state = ASRC_FROZEN;
                    end else begin
                        nxt_r.conv_start = 1'b1;
                    end
                end else if (freeze_i && brk == 2'b11) begin
                    // stop at once: core holds its partial state
                    nxt_r.state = ASRC_FINISH;
                end else if (freeze_i && brk == 2'b10) begin
                    nxt_r.state = ASRC_CONV;                 // finish first
                end
            end
            ASRC_FINISH: begin
                // immediate freeze holding a partial conversion
                if (!freeze_i || brk != 2'b11) begin
                    nxt_r.state = ASRC_CONV;
                end
            end
            ASRC_FROZEN: begin
                if (!freeze_i || !brk[1]) begin              // 00/01 continue
                    nxt_r.conv_start = 1'b1;
                    nxt_r.state      = ASRC_CONV;
                end
            end
            default: begin
                nxt_r.state = ASRC_IDLE;
            end
        endcase

        // any converter control write aborts and clears the counter
        if (conv_ctrl_wr) begin
            if (r_ff.state != ASRC_IDLE) begin
                ev_abort = 1'b1;
                nxt_r.conv_abort = 1'b1;
            end
            nxt_r.state       = ASRC_IDLE;
            nxt_r.conv_start  = 1'b0;
            nxt_r.start_pend  = 1'b0;
            nxt_r.cnt         = 3'h0;
            nxt_r.done_in_seq = 4'h0;
            if (idx == `ASRC_IDX_CTRL) begin
                nxt_r.ctrl = dat_i[6:0];
            end
            if (idx == `ASRC_IDX_START) begin
                // start register: bit 5 selects continuous scan
                nxt_r.scan       = dat_i[5];
                nxt_r.start_pend = 1'b1;
            end
        end

        // completion flags: new result wins over a clear
        if (ccf_clr_i) begin
            nxt_r.ccf = nxt_r.ccf & ~ccf_clr_mask_i;
            if (ev_conv) begin
                nxt_r.ccf[r_ff.cnt] = 1'b1;
            end
        end

        // interrupt status: set wins over clear
        if (wr && lane0 && idx == `ASRC_IDX_IRQ_CLR) begin
            clr = dat_i[2:0];
        end
        nxt_r.irq_stat = (r_ff.irq_stat & ~clr)
                       | {ev_abort, ev_conv, ev_seq};
        if (wr && lane0 && idx == `ASRC_IDX_IRQ_EN) begin
            nxt_r.irq_en = dat_i[2:0];
        end
        nxt_r.irq = |(nxt_r.irq_stat & nxt_r.irq_en);

        // bus answer one cycle after the request
        if ((wr || rd) && !r_ff.ack) begin
            nxt_r.ack = 1'b1;
            nxt_r.dat = 32'h0000_0000;
            if (rd) begin
                case (idx)
                    `ASRC_IDX_CTRL:     nxt_r.dat = {25'h0, r_ff.ctrl};
                    `ASRC_IDX_STATUS:   nxt_r.dat = {29'h0, r_ff.cnt};
                    `ASRC_IDX_CCF:      nxt_r.dat = {24'h0, r_ff.ccf};
                    `ASRC_IDX_IRQ_STAT: nxt_r.dat = {29'h0, r_ff.irq_stat};
                    `ASRC_IDX_IRQ_EN:   nxt_r.dat = {29'h0, r_ff.irq_en};
                    default:            nxt_r.dat = 32'h0000_0000;
                endcase
            end
        end
    end

    // ****************************************************************
    // state register
    // ****************************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r_ff <= '{state: ASRC_IDLE, ctrl: 7'h20, default: '0};
        end else begin
            r_ff <= nxt_r;
        end
    end

    // outputs straight from flops
    assign dat_o        = r_ff.dat;
    assign ack_o        = r_ff.ack;
    assign conv_start_o = r_ff.conv_start;
    assign conv_abort_o = r_ff.conv_abort;
    assign result_idx_o = r_ff.cnt;
    assign ccf_o        = r_ff.ccf;
    assign irq_o        = r_ff.irq;
endmodule // asrc_seq_ctrl

// ---- shared/asrc_map.svh ----
// constants for the converter sequence control block: offsets, fields, resets
// assumes a 32-bit wishbone slave with word-aligned registers
`ifndef ASRC_MAP_SVH
`define ASRC_MAP_SVH
// register indices (byte address is four times the index)
`define ASRC_IDX_CTRL      4'h3
`define ASRC_IDX_STATUS    4'h8
`define ASRC_IDX_START     4'h5
`define ASRC_IDX_CCF       4'h9
`define ASRC_IDX_IRQ_STAT  4'hA
`define ASRC_IDX_IRQ_EN    4'hB
`define ASRC_IDX_IRQ_CLR   4'hC
`define ASRC_IDX_RESULT0   4'h0
`define ASRC_IDX_OTHER_LO  4'h0
`define ASRC_IDX_OTHER_HI  4'h6
// control field positions
`define ASRC_LEN_MSB       6
`define ASRC_LEN_LSB       3
`define ASRC_WRAP_BIT      2
`define ASRC_BRK_MSB       1
`define ASRC_BRK_LSB       0
`define ASRC_CTRL_RESET    8'h20
`define ASRC_CTRL_MASK     8'h7F
// interrupt status bits
`define ASRC_IRQ_SEQ_DONE  0
`define ASRC_IRQ_CONV_DONE 1
`define ASRC_IRQ_ABORT     2
`endif

// ---- shared/asrc_pkg.sv ----
// types for the converter sequence control block
// assumes asrc_map.svh supplies the numeric constants
package asrc_pkg;
    typedef enum logic [3:0] {
        ASRC_IDLE   = 4'b0001,
        ASRC_CONV   = 4'b0010,
        ASRC_FROZEN = 4'b0100,
        ASRC_FINISH = 4'b1000
    } asrc_state_t;

    typedef struct packed {
        asrc_state_t state;
        logic [6:0]  ctrl;
        logic [2:0]  cnt;
        logic [3:0]  done_in_seq;
        logic        scan;
        logic        start_pend;
        logic [7:0]  ccf;
        logic [2:0]  irq_stat;
        logic [2:0]  irq_en;
        logic        irq;
        logic        ack;
        logic [31:0] dat;
        logic        conv_start;
        logic        conv_abort;
    } asrc_regs_t;
endpackage

// ---- logic/asrc_len_decode.sv ----
// length decoder for the sequence length field
// assumes the four-bit field as stored in the control register
module asrc_len_decode
    import asrc_pkg::*;
(
    input  wire logic [3:0] len_field_i, // stored length field
    output logic      [3:0] len_o        // conversions per sequence, 1 to 8
);
    // top bit forces eight; zero in the low bits also means eight
    always_comb begin
        if (len_field_i[3] || (len_field_i[2:0] == 3'h0)) begin
            len_o = 4'h8;
        end else begin
            len_o = {1'b0, len_field_i[2:0]};
        end
    end
endmodule // asrc_len_decode

// ---- verification/asrc_seq_monitor.sv ----
// checker for the sequence control block: bus handshake, counter, flags, freeze
// assumes it is bound to asrc_seq_ctrl and sees only that module's ports
`include "asrc_map.svh"
module asrc_seq_monitor (
    input wire logic        clk_i,        // clock
    input wire logic        rst_i,        // reset
    input wire logic        cyc_i,        // cycle
    input wire logic        stb_i,        // strobe
    input wire logic        we_i,         // write
    input wire logic [5:0]  adr_i,        // address
    input wire logic [3:0]  sel_i,        // byte enables
    input wire logic [31:0] dat_i,        // write data
    input wire logic [31:0] dat_o,        // read data
    input wire logic        ack_o,        // acknowledge
    input wire logic        freeze_i,     // breakpoint
    input wire logic        conv_done_i,  // core done
    input wire logic        conv_start_o, // core start
    input wire logic        conv_abort_o, // core abort
    input wire logic [2:0]  result_idx_o, // counter
    input wire logic [7:0]  ccf_o         // flags
);
    // ********
    // shadow of the control register
    // ********
    logic [6:0] ctl_ff;
    wire        wr_ctl = ack_o && we_i && sel_i[0] && adr_i[5:2] == `ASRC_IDX_CTRL;
    wire        wr_any = ack_o && we_i && sel_i[0] && adr_i[5:2] <= 4'h5;
    // lags the design by a cycle, so freeze checks wait three cycles
    always_ff @(posedge clk_i) begin
        ctl_ff <= rst_i ? 7'h20 : (wr_ctl ? dat_i[6:0] : ctl_ff);
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_take;
        cyc_i && stb_i && !ack_o;
    endsequence
    sequence s_frozen;
        (freeze_i && ctl_ff[1]) [*3];
    endsequence
    a_ack_follows: assert property (s_take |=> ack_o)
        else $error("no acknowledge after request");
    a_ack_single: assert property (ack_o |=> !ack_o)
        else $error("acknowledge longer than one cycle");
    a_ctrl_read: assert property (ack_o && !we_i && adr_i[5:2] == `ASRC_IDX_CTRL
        |-> dat_o == {25'h000_0000, ctl_ff}) else $error("control read back wrong");
    a_write_no_start: assert property (wr_ctl |=> !conv_start_o [*2])
        else $error("control write started a conversion");
    a_write_clr_cnt: assert property (wr_any && !conv_done_i && !$past(conv_done_i)
        |=> result_idx_o == 3'h0) else $error("counter not cleared by write");
    a_cnt_steps: assert property ($changed(result_idx_o) |->
        result_idx_o == $past(result_idx_o) + 3'h1 || result_idx_o == 3'h0)
        else $error("counter jumped");
    // a result landing just after an abort is dropped by the idle sequencer
    a_flag_set: assert property (conv_done_i && !conv_abort_o |=> ccf_o[$past(result_idx_o)])
        else $error("completion flag not set");
    a_freeze_hold: assert property (s_frozen |-> !conv_start_o)
        else $error("conversion started while frozen");
endmodule // asrc_seq_monitor

bind asrc_seq_ctrl asrc_seq_monitor u_mon (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i,
    .sel_i, .dat_i, .dat_o, .ack_o, .freeze_i, .conv_done_i, .conv_start_o, .conv_abort_o,
    .result_idx_o, .ccf_o);

// ---- verification/tb_top.sv ----
// self-checking bench for the converter sequence control block
// assumes design and checker compiled first; the bench plays bus master and core
`include "asrc_map.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, freeze_i = 0;
    logic        conv_done_i = 0, ccf_clr_i = 0, ack_o, conv_start_o, conv_abort_o, irq_o;
    logic [5:0]  adr_i = '0;
    logic [3:0]  sel_i = '0;
    logic [31:0] dat_i = '0, dat_o, rd;
    logic [7:0]  ccf_clr_mask_i = '0, ccf_o, exp_q[$];
    logic [2:0]  result_idx_o;
    logic [1:0]  b;
    int          n_mismatch = 0, checks = 0, n_start = 0, seed = 623, k, n;
    bit          loose = 0, ab;
    logic        ab_seen;
    asrc_seq_ctrl u_dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
        .dat_o, .ack_o, .freeze_i, .conv_done_i, .ccf_clr_i, .ccf_clr_mask_i, .conv_start_o,
        .conv_abort_o, .result_idx_o, .ccf_o, .irq_o);
    // ********
    // helpers
    // ********
    initial forever #2 clk_i = ~clk_i;
    task chk(input string nm, input logic [7:0] s, e);
        checks++;
        if (s !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask
    // waits for ack without assuming a latency; two edges of rest follow
    task bus(input logic w, input logic [3:0] ix, input logic [7:0] d, input logic [3:0] s);
        int t;
        t = 0;
        cyc_i <= 1; stb_i <= 1; we_i <= w; sel_i <= s;
        adr_i <= {ix, 2'b00};
        dat_i <= {24'h00_0000, d};
        do begin @(posedge clk_i); t++; end while (ack_o !== 1'b1 && t < 50);
        if (t == 50) n_mismatch++;
        rd = dat_o;
        ab_seen = conv_abort_o;
        cyc_i <= 0; stb_i <= 0; we_i <= 0;
        repeat (2) @(posedge clk_i);
    endtask
    task wr(input logic [3:0] ix, input logic [7:0] d); bus(1, ix, d, 4'h1); endtask
    task rdc(input string nm, input logic [3:0] ix, input logic [7:0] e);
        bus(0, ix, 8'h00, 4'h1);
        chk(nm, rd[7:0], e);
    endtask
    task clr;
        ccf_clr_i <= 1; ccf_clr_mask_i <= 8'hFF;
        @(posedge clk_i);
        ccf_clr_i <= 0;
    endtask
    // notes the expected destinations, then starts the sequence
    task go(input int m, input logic [7:0] s);
        for (int i = 0; i < m; i++) exp_q.push_back(8'(i % 8));
        wr(`ASRC_IDX_START, s);
    endtask
    task drain;
        int t;
        t = 0;
        while (exp_q.size() > 0 && t < 500) begin @(posedge clk_i); t++; end
        repeat (10) @(posedge clk_i);
    endtask
    task close_out;
        $display("counts: %0d compared, %0d mismatched", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // core stand-in: random latency, drops the answer when aborted
    initial forever begin
        @(posedge clk_i);
        if (conv_start_o === 1'b1) begin
            n_start++;
            ab = 0;
            repeat (2 + $unsigned($random(seed)) % 4) begin @(posedge clk_i); ab |= conv_abort_o; end
            if (!ab) begin conv_done_i <= 1; @(posedge clk_i); conv_done_i <= 0; end
        end
    end
    // each finished conversion takes the oldest noted destination
    always @(posedge clk_i) begin
        if (conv_done_i === 1'b1) begin
            if (exp_q.size() > 0) chk("result index", 8'(result_idx_o), exp_q.pop_front());
            else if (!loose) chk("extra conversion", 8'h01, 8'h00);
        end
    end
    initial begin repeat (40000) @(posedge clk_i); n_mismatch++; close_out; end
    // ********
    // tests
    // ********
    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 0;
        @(posedge clk_i);
        rdc("control reset", `ASRC_IDX_CTRL, 8'h20);
        rdc("counter reset", `ASRC_IDX_STATUS, 8'h00);
        rdc("unmapped read", 4'hF, 8'h00);
        bus(1, `ASRC_IDX_CTRL, 8'h7F, 4'h0);
        rdc("unselected write", `ASRC_IDX_CTRL, 8'h20);
        $display("test reset done");
        // every length code, breakpoint codes that keep converting
        for (int c = 0; c < 16; c++) begin
            b = 2'($unsigned($random(seed)) % 2);
            freeze_i <= $random(seed);
            clr;
            wr(`ASRC_IDX_CTRL, {1'b0, 4'(c), 1'b0, b});
            n = c[3] ? 8 : (c[2:0] == 0 ? 8 : c[2:0]);
            go(n, 8'h00);
            drain;
            chk("flags", ccf_o, 8'((16'h1 << n) - 1));
        end
        freeze_i <= 0;
        $display("test lengths done");
        wr(`ASRC_IDX_IRQ_EN, 8'h00);
        chk("irq masked", 8'(irq_o), 8'h00);
        wr(`ASRC_IDX_IRQ_EN, 8'h01);
        chk("irq raised", 8'(irq_o), 8'h01);
        rdc("irq status", `ASRC_IDX_IRQ_STAT, 8'h03);
        wr(`ASRC_IDX_IRQ_CLR, 8'h07);
        chk("irq cleared", 8'(irq_o), 8'h00);
        $display("test interrupts done");
        // wrapping placement: one-shot restarts at zero, scanning wraps past seven
        wr(`ASRC_IDX_CTRL, 8'h1C);
        go(3, 8'h00); drain;
        go(3, 8'h00); drain;
        loose = 1;
        go(11, 8'h20); drain;
        wr(`ASRC_IDX_CTRL, 8'h1C);
        chk("abort pulse", 8'(ab_seen), 8'h01);
        k = n_start;
        repeat (20) @(posedge clk_i);
        chk("starts after abort", 8'(n_start - k), 8'h00);
        rdc("counter after abort", `ASRC_IDX_STATUS, 8'h00);
        rdc("irq status abort", `ASRC_IDX_IRQ_STAT, 8'h07);
        exp_q.delete();
        loose = 0;
        $display("test wrapping done");
        // finish-then-stop: the running conversion still lands
        wr(`ASRC_IDX_CTRL, 8'h22);
        clr;
        k = n_start;
        go(4, 8'h00);
        while (n_start == k) @(posedge clk_i);
        freeze_i <= 1;
        repeat (20) @(posedge clk_i);
        chk("starts while frozen", 8'(n_start - k), 8'h01);
        chk("frozen flags", ccf_o, 8'h01);
        freeze_i <= 0;
        drain;
        $display("test freeze done");
        close_out;
    end
endmodule // tb_top
